// file: hw/atps_pkg.sv
// Constants and carrier types for the converter trigger program select block.
// Assumes one system clock; triggers arrive from logic on that same clock.
package atps_pkg;

    // ==========================================================
    // Geometry
    localparam int          NUM_TRIG      = 6;
    localparam int          ADDR_W        = 8;
    localparam int          PROG_W        = 3;

    // ==========================================================
    // Register map (byte addresses, one word each)
    localparam logic [7:0]  SEL_FIRST_ADDR = 8'h08;
    localparam logic [7:0]  SEL_LAST_ADDR  = 8'h1C;
    localparam logic [7:0]  STATUS_ADDR    = 8'h20;

    // ==========================================================
    // Field layout of a select register
    localparam int          ENABLE_BIT    = 7;
    localparam int          PROG_LSB      = 0;
    localparam logic [2:0]  PROG_MAX      = 3'h5;
    localparam logic        ENABLE_RESET  = 1'h0;
    localparam logic [2:0]  PROG_RESET    = 3'h0;

    // ==========================================================
    // Status register layout
    localparam int          STAT_PEND_LSB = 0;
    localparam int          STAT_BUSY_BIT = 8;

    // Program start request toward the sequencer
    typedef struct packed {
        logic       valid;
        logic [2:0] program_num;
        logic [2:0] source;
    } atps_start_t;

    // Whole state of the block
    typedef struct packed {
        logic [5:0]      enable;
        logic [5:0][2:0] program_num;
        logic [5:0]      pending;
        atps_start_t     start;
        logic [31:0]     rdata;
    } atps_state_t;

endpackage

// file: hw/atps_top.sv
// Trigger program select: six select registers route motor driver
// trigger pulses to conversion program start requests.
// Assumes triggers and seq_ready_in come from logic on clk_sys_in.
//
// Notes on behaviour
// - Select 2 bit 7 gates group0 trigger 2
// - Select 3 bit 7 gates group0 trigger 3
// - Select 4 bit 7 gates group0 trigger 4
// - Select 5 bit 7 gates group0 trigger 5
// - Select 6 bit 7 gates group1 trigger 0
// - Select 7 bit 7 gates group1 trigger 1
// - Bits 2:0 hold read/write program number
// - Codes 0-5 are programs; 6,7 reserved
// - Each trigger starts its own selected program
`timescale 1ns/1ps
`default_nettype none

module atps_top (
    // Clock and reset
    input  wire logic                         clk_sys_in,
    input  wire logic                         rst_n_in,
    // Register port
    input  wire logic [atps_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [31:0]                  reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic      [31:0]                  reg_rdata_out,
    // Motor driver triggers
    input  wire logic                         motor0_trigger_2_in,
    input  wire logic                         motor0_trigger_3_in,
    input  wire logic                         motor0_trigger_4_in,
    input  wire logic                         motor0_trigger_5_in,
    input  wire logic                         motor1_trigger_0_in,
    input  wire logic                         motor1_trigger_1_in,
    // Program start toward the sequencer
    input  wire logic                         seq_ready_in,
    output atps_pkg::atps_start_t             start_out
);

    // ==========================================================
    // Helpers
    function automatic logic prog_valid(input logic [2:0] code);
        prog_valid = (code <= atps_pkg::PROG_MAX);
    endfunction

    function automatic logic sel_hit(input logic [7:0] addr);
        sel_hit = (addr[1:0] == 2'h0) &&
                  (addr >= atps_pkg::SEL_FIRST_ADDR) &&
                  (addr <= atps_pkg::SEL_LAST_ADDR);
    endfunction

    function automatic logic [2:0] sel_slot(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - atps_pkg::SEL_FIRST_ADDR;
        sel_slot = diff[4:2];
    endfunction

    // ==========================================================
    // State
    atps_pkg::atps_state_t state_reg;
    atps_pkg::atps_state_t state_next;
    logic [5:0]            trig;
    logic                  wr_sel;
    logic                  rd_sel;
    logic [2:0]            slot;
    logic                  picked;

    assign trig = {motor1_trigger_1_in, motor1_trigger_0_in,
                   motor0_trigger_5_in, motor0_trigger_4_in,
                   motor0_trigger_3_in, motor0_trigger_2_in};
    assign slot   = sel_slot(reg_addr_in);
    assign wr_sel = reg_wr_in && sel_hit(reg_addr_in);
    assign rd_sel = reg_rd_in && sel_hit(reg_addr_in);

    always_comb begin
        state_next = state_reg;
        picked     = 1'b0;
        state_next.rdata = 32'h0000_0000;

        // Request stands until the sequencer takes it
        if (state_reg.start.valid && seq_ready_in) begin
            state_next.start.valid = 1'b0;
        end

        // Launch lowest pending trigger; fixed priority keeps it simple
        if (!state_next.start.valid) begin
            for (int i = 0; i < atps_pkg::NUM_TRIG; i++) begin
                if (!picked && state_reg.pending[i]) begin
                    picked = 1'b1;
                    state_next.pending[i]         = 1'b0;
                    state_next.start.valid        = 1'b1;
                    state_next.start.program_num  =
                        state_reg.program_num[i];
                    state_next.start.source       = 3'(i);
                end
            end
        end

        // Register write; only bit 7 and bits 2:0 are stored
        if (wr_sel) begin
            state_next.enable[slot] = reg_wdata_in[atps_pkg::ENABLE_BIT];
            state_next.program_num[slot] =
                reg_wdata_in[atps_pkg::PROG_LSB +: 3];
            // Disabling drops a trigger not yet launched
            if (!reg_wdata_in[atps_pkg::ENABLE_BIT]) begin
                state_next.pending[slot] = 1'b0;
            end
        end

        // Trigger capture comes last so a new trigger beats any clear
        for (int i = 0; i < atps_pkg::NUM_TRIG; i++) begin
            if (trig[i] && state_reg.enable[i] &&
                prog_valid(state_reg.program_num[i])) begin
                state_next.pending[i] = 1'b1;
            end
        end

        // Read data stand only in the cycle after the strobe
        if (rd_sel) begin
            state_next.rdata[atps_pkg::ENABLE_BIT] =
                state_reg.enable[slot];
            state_next.rdata[atps_pkg::PROG_LSB +: 3] =
                state_reg.program_num[slot];
        end else if (reg_rd_in && reg_addr_in == atps_pkg::STATUS_ADDR) begin
            state_next.rdata[atps_pkg::STAT_PEND_LSB +: 6] = state_reg.pending;
            state_next.rdata[atps_pkg::STAT_BUSY_BIT] = state_reg.start.valid;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out = state_reg.rdata;
    assign start_out     = state_reg.start;

endmodule

`default_nettype wire

// file: tb/atps_top_bench.sv
// Self-checking bench for atps_top fed by the trigger model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module atps_top_bench;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
    logic rdy = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [5:0] fm = 6'h0, trig;
    atps_pkg::atps_start_t st;
    int err_total = 0, samples_checked = 0;
    atps_trig_model i_trig (.clk_in(clk_sys_in), .fire_in(fm),
        .trig_out(trig));
    atps_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .seq_ready_in(rdy),
        .motor0_trigger_2_in(trig[0]), .motor0_trigger_3_in(trig[1]),
        .motor0_trigger_4_in(trig[2]), .motor0_trigger_5_in(trig[3]),
        .motor1_trigger_0_in(trig[4]), .motor1_trigger_1_in(trig[5]),
        .start_out(st));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    initial begin
        #200000;
        err_total++;
        close_out();
    end
    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A write leaves its strobe up so a following call may drive it again
    // without a second assignment in one time step; fire() drops it.
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_sys_in);
        if (!w) begin
            wr <= 1'b0;
            rd <= 1'b0;
            @(negedge clk_sys_in) chk(rdata, d);
            @(posedge clk_sys_in);
        end
    endtask
    task automatic fire(logic [5:0] m, logic [31:0] e);
        logic [6:0] s;
        fm <= m;
        wr <= 1'b0;
        @(posedge clk_sys_in);
        fm <= 6'h0;
        s = 7'h0;
        repeat (8) @(negedge clk_sys_in)
            if (st.valid === 1'b1 && s == 7'h0) s = st;
        chk(32'(s), e);
        @(posedge clk_sys_in);
    endtask
    initial begin
        logic [2:0] p;
        logic [7:0] a;
        logic [31:0] d;
        d = $urandom(32'hF84E7427);
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int i = 0; i < 6; i++) begin
            a = 8'h08 + 8'(4 * i);
            p = 3'($urandom % 6);
            d = $urandom;
            acc(1'b0, a, 32'h0);
            acc(1'b1, a, {d[31:8], 1'b1, d[6:3], p});
            acc(1'b0, a, {24'h0, 1'b1, 4'h0, p});
            fire(6'h01 << i,
                {25'h0, 1'b1, p, 3'(i)});
            acc(1'b1, a, {d[31:8], 1'b0, d[6:3], p});
            fire(6'h01 << i, 32'h0);
        end
        for (int c = 6; c < 8; c++) begin
            acc(1'b1, 8'h08, 32'h80 | 32'(c));
            fire(6'h01, 32'h0);
        end
        acc(1'b1, 8'h1C, 32'h84);
        acc(1'b0, 8'h1C, 32'h84);
        acc(1'b1, 8'h08, 32'h82);
        rdy <= 1'b0;
        fire(6'h21, 32'h50);
        rdy <= 1'b1;
        @(posedge clk_sys_in);
        @(negedge clk_sys_in) chk(32'(st), 32'h65);
        @(posedge clk_sys_in);
        wr <= 1'b0;
        @(posedge clk_sys_in);
        acc(1'b0, 8'h20, 32'h0);
        acc(1'b0, 8'h40, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire

// file: tb/atps_top_sva.sv
// Port checker for the trigger program select block.
// Assumes bind onto atps_top with one clock domain.
`timescale 1ns/1ps
`default_nettype none
module atps_top_sva (
    input wire logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in,
    input wire logic [atps_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in, reg_rdata_out,
    input wire logic motor0_trigger_2_in, motor0_trigger_3_in,
    input wire logic motor0_trigger_4_in, motor0_trigger_5_in,
    input wire logic motor1_trigger_0_in, motor1_trigger_1_in,
    input wire logic seq_ready_in,
    input wire atps_pkg::atps_start_t start_out
);
    wire logic [5:0] tv = {motor1_trigger_1_in, motor1_trigger_0_in,
        motor0_trigger_5_in, motor0_trigger_4_in, motor0_trigger_3_in,
        motor0_trigger_2_in};
    wire logic sel = reg_addr_in inside {[8'h08:8'h1C]} && ~|reg_addr_in[1:0];
    // Slots that have ever pulsed; queued launches may come much later
    logic [5:0] seen;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen <= 6'h00;
        end else begin
            seen <= seen | tv;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    AST_RD_IDLE: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("rdata");
    AST_RD_RSVD: assert property (
        $past(reg_rd_in && sel) |-> !(reg_rdata_out & 32'hFFFFFF78))
        else $error("reserved bits");
    AST_WR_RD: assert property (
        $past(reg_wr_in && sel, 2) && $past(reg_rd_in) && $past(reg_addr_in)
        == $past(reg_addr_in, 2) |-> reg_rdata_out ==
        ($past(reg_wdata_in, 2) & 32'h87)) else $error("readback");
    AST_UNMAP: assert property (
        $past(reg_rd_in && reg_addr_in > 8'h20) |-> !reg_rdata_out)
        else $error("unmapped");
    AST_STATUS: assert property (
        $past(reg_rd_in && reg_addr_in == 8'h20) |-> !(reg_rdata_out &
        32'hFFFFFEC0)) else $error("status");
    AST_RANGE: assert property (
        start_out.valid |-> start_out.program_num <= 3'h5 &&
        start_out.source <= 3'h5) else $error("range");
    AST_HOLD: assert property (
        start_out.valid && !seq_ready_in |=> start_out.valid &&
        $stable(start_out)) else $error("hold");
    AST_LAUNCH: assert property (
        $rose(start_out.valid) |-> seen[start_out.source])
        else $error("launch");
endmodule
`default_nettype wire
bind atps_top atps_top_sva i_sva (.*);

// file: tb/atps_trig_model.sv
// Motor driver trigger source: trig_out repeats fire_in one cycle later.
// Assumes fire_in is driven by the bench just after clk_in edges.
`timescale 1ns/1ps
`default_nettype none
module atps_trig_model (
    input  wire logic       clk_in,
    input  wire logic [5:0] fire_in,
    output logic      [5:0] trig_out
);
    // Registers fire_in as is, so a held fire_in gives a held trig_out
    always_ff @(posedge clk_in) trig_out <= fire_in;
endmodule
`default_nettype wire
